//--- rtl/irq_prio_pkg.sv
// package of constants for the interrupt priority register bank
// assumes a 32-bit word-addressed register port with byte addresses
package irq_prio_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] GROUP0_ADDR = 32'hE000_E400;
  localparam logic [31:0] GROUP1_ADDR = 32'hE000_E404;
  localparam logic [31:0] GROUP2_ADDR = 32'hE000_E408;
  localparam logic [31:0] GROUP3_ADDR = 32'hE000_E40C;
  localparam logic [31:0] GROUP6_ADDR = 32'hE000_E418;
  localparam logic [31:0] GROUP7_ADDR = 32'hE000_E41C;

  // word indices of the groups, source number = 4 * word + lane
  localparam logic [2:0] GROUP0_IDX = 3'h0;
  localparam logic [2:0] GROUP1_IDX = 3'h1;
  localparam logic [2:0] GROUP2_IDX = 3'h2;
  localparam logic [2:0] GROUP3_IDX = 3'h3;
  localparam logic [2:0] GROUP6_IDX = 3'h6;
  localparam logic [2:0] GROUP7_IDX = 3'h7;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int SRC_COUNT = 32;
  localparam int LANES_PER_WORD = 4;
  localparam int LANE_W = 8;
  localparam int LEVEL_W = 2;
  localparam int LEVEL_LSB = 6;
  // sources that own a priority field; the rest read zero, ignore writes
  localparam logic [31:0] IMPL_MASK = 32'hFF00_FF3B;
  // low six bits of each lane are hard zero
  localparam logic [31:0] LANE_ZERO_MASK = 32'h3F3F_3F3F;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage : irq_prio_pkg

//--- rtl/irq_priority_register_bank.sv
// priority register bank and request selector for the peripheral interrupts
// assumes a same-clock register port master and same-clock pending/enable
// vectors from the surrounding controller logic
//
// Functional notes
// - each priority word carries four sources, one per byte lane
// - every source that owns a field (IMPL_MASK) has a two-bit level, one of four values
// - level zero is most urgent, level three least urgent
// - low six bits of every lane ignore writes and read zero
// - word zero: serial port 0 at 7:6, port 1 at 15:14, async port 0 at 31:30
// - word one: async port 1 at 7:6, async port 2 at 15:14, rest reserved
// - word two: two-wire, state timer, multirate timer, comparator lanes
// - word three: watchdog, brownout, nvm controller, wakeup timer lanes
// - word six: pin events 0 to 3 in lanes 0 to 3
// - word seven: pin events 4 to 7 in lanes 0 to 3
`timescale 1ns/100ps

module irq_priority_register_bank (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [31:0] irq_pending_i,
  input wire logic [31:0] irq_enable_i,
  output logic irq_req_valid_o,
  output logic [4:0] irq_req_num_o,
  output logic [1:0] irq_req_level_o,
  output logic [1:0] serial_port0_level_o,
  output logic [1:0] serial_port1_level_o,
  output logic [1:0] async_port0_level_o,
  output logic [1:0] async_port1_level_o,
  output logic [1:0] async_port2_level_o,
  output logic [1:0] two_wire_level_o,
  output logic [1:0] state_timer_level_o,
  output logic [1:0] multirate_timer_level_o,
  output logic [1:0] comparator_level_o,
  output logic [1:0] watchdog_level_o,
  output logic [1:0] brownout_level_o,
  output logic [1:0] nvm_controller_level_o,
  output logic [1:0] wakeup_timer_level_o,
  output logic [1:0] pin_event0_level_o,
  output logic [1:0] pin_event1_level_o,
  output logic [1:0] pin_event2_level_o,
  output logic [1:0] pin_event3_level_o,
  output logic [1:0] pin_event4_level_o,
  output logic [1:0] pin_event5_level_o,
  output logic [1:0] pin_event6_level_o,
  output logic [1:0] pin_event7_level_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef logic [irq_prio_pkg::SRC_COUNT-1:0][irq_prio_pkg::LEVEL_W-1:0] level_array_t;

  typedef struct packed {
    level_array_t levels;
    logic [31:0] rdata;
    logic req_valid;
    logic [4:0] req_num;
    logic [1:0] req_level;
  } state_t;

  localparam state_t STATE_RESET = '{
    levels: {irq_prio_pkg::SRC_COUNT{irq_prio_pkg::LEVEL_RESET}},
    rdata: irq_prio_pkg::RDATA_RESET,
    req_valid: 1'b0,
    req_num: 5'h00,
    req_level: irq_prio_pkg::LEVEL_RESET
  };

  state_t state;
  state_t next_state;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // {hit, word index}; only the six documented words answer
  function automatic logic [3:0] decode_word(input logic [31:0] addr);
    logic [3:0] r;
    r = 4'h0;
    case (addr)
      irq_prio_pkg::GROUP0_ADDR: r = {1'b1, irq_prio_pkg::GROUP0_IDX};
      irq_prio_pkg::GROUP1_ADDR: r = {1'b1, irq_prio_pkg::GROUP1_IDX};
      irq_prio_pkg::GROUP2_ADDR: r = {1'b1, irq_prio_pkg::GROUP2_IDX};
      irq_prio_pkg::GROUP3_ADDR: r = {1'b1, irq_prio_pkg::GROUP3_IDX};
      irq_prio_pkg::GROUP6_ADDR: r = {1'b1, irq_prio_pkg::GROUP6_IDX};
      irq_prio_pkg::GROUP7_ADDR: r = {1'b1, irq_prio_pkg::GROUP7_IDX};
      default: r = 4'h0;
    endcase
    return r;
  endfunction : decode_word

  // assemble one word; unowned fields and low lane bits stay zero
  function automatic logic [31:0] read_word(input level_array_t lv, input logic [2:0] w);
    logic [31:0] r;
    logic [4:0] idx;
    r = 32'h0000_0000;
    idx = 5'h00;
    for (int k = 0; k < irq_prio_pkg::LANES_PER_WORD; k++) begin
      idx = {w, 2'(k)};
      if (irq_prio_pkg::IMPL_MASK[idx]) begin
        r[k*irq_prio_pkg::LANE_W+irq_prio_pkg::LEVEL_LSB +: irq_prio_pkg::LEVEL_W] = lv[idx];
      end
    end
    return r;
  endfunction : read_word

  // {found, number, level}; strict less-than keeps the lower number on a tie
  function automatic logic [7:0] pick_best(input logic [31:0] cand, input level_array_t lv);
    logic found;
    logic [4:0] num;
    logic [1:0] lvl;
    found = 1'b0;
    num = 5'h00;
    lvl = 2'h3;
    for (int i = 0; i < irq_prio_pkg::SRC_COUNT; i++) begin
      if (cand[i] && (!found || lv[i] < lvl)) begin
        found = 1'b1;
        num = 5'(i);
        lvl = lv[i];
      end
    end
    return {found, num, lvl};
  endfunction : pick_best

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [3:0] dec;
  logic [31:0] cand;
  logic [7:0] best;

  always_comb begin
    next_state = state;
    dec = decode_word(addr_i);
    // reserved sources never compete, even if pending
    cand = irq_pending_i & irq_enable_i & irq_prio_pkg::IMPL_MASK;
    best = pick_best(cand, state.levels);
    if (wr_i && dec[3]) begin
      for (int k = 0; k < irq_prio_pkg::LANES_PER_WORD; k++) begin
        // only the two level bits of an owned lane are stored
        if (irq_prio_pkg::IMPL_MASK[{dec[2:0], 2'(k)}]) begin
          next_state.levels[{dec[2:0], 2'(k)}] =
            wdata_i[k*irq_prio_pkg::LANE_W+irq_prio_pkg::LEVEL_LSB +: irq_prio_pkg::LEVEL_W];
        end
      end
    end
    // unmapped reads answer zero; data stands for one cycle only
    next_state.rdata = 32'h0000_0000;
    if (rd_i && dec[3]) begin
      next_state.rdata = read_word(state.levels, dec[2:0]);
    end
    next_state.req_valid = best[7];
    next_state.req_num = best[6:2];
    next_state.req_level = best[1:0];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_o = state.rdata;
  assign irq_req_valid_o = state.req_valid;
  assign irq_req_num_o = state.req_num;
  assign irq_req_level_o = state.req_level;
  assign serial_port0_level_o = state.levels[0];
  assign serial_port1_level_o = state.levels[1];
  assign async_port0_level_o = state.levels[3];
  assign async_port1_level_o = state.levels[4];
  assign async_port2_level_o = state.levels[5];
  assign two_wire_level_o = state.levels[8];
  assign state_timer_level_o = state.levels[9];
  assign multirate_timer_level_o = state.levels[10];
  assign comparator_level_o = state.levels[11];
  assign watchdog_level_o = state.levels[12];
  assign brownout_level_o = state.levels[13];
  assign nvm_controller_level_o = state.levels[14];
  assign wakeup_timer_level_o = state.levels[15];
  assign pin_event0_level_o = state.levels[24];
  assign pin_event1_level_o = state.levels[25];
  assign pin_event2_level_o = state.levels[26];
  assign pin_event3_level_o = state.levels[27];
  assign pin_event4_level_o = state.levels[28];
  assign pin_event5_level_o = state.levels[29];
  assign pin_event6_level_o = state.levels[30];
  assign pin_event7_level_o = state.levels[31];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [31:0] cand_q;
  logic better_seen;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cand_q <= 32'h0000_0000;
    end else begin
      cand_q <= cand;
    end
  end

  // any earlier candidate that should have beaten the presented one
  always_comb begin
    better_seen = 1'b0;
    for (int i = 0; i < irq_prio_pkg::SRC_COUNT; i++) begin
      if (cand_q[i] && (state.levels[i] < state.req_level ||
          (state.levels[i] == state.req_level && 5'(i) < state.req_num))) begin
        better_seen = 1'b1;
      end
    end
  end

  chk_word0_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == irq_prio_pkg::GROUP0_ADDR |=>
      serial_port0_level_o == $past(wdata_i[7:6]) &&
      serial_port1_level_o == $past(wdata_i[15:14]) &&
      async_port0_level_o == $past(wdata_i[31:30]))
    else $error("word zero write not stored in its lanes");

  chk_word1_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == irq_prio_pkg::GROUP1_ADDR |=>
      async_port1_level_o == $past(wdata_i[7:6]) &&
      async_port2_level_o == $past(wdata_i[15:14]))
    else $error("word one write not stored in its lanes");

  chk_word2_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == irq_prio_pkg::GROUP2_ADDR |=>
      two_wire_level_o == $past(wdata_i[7:6]) &&
      state_timer_level_o == $past(wdata_i[15:14]) &&
      multirate_timer_level_o == $past(wdata_i[23:22]) &&
      comparator_level_o == $past(wdata_i[31:30]))
    else $error("word two write not stored in its lanes");

  chk_word3_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == irq_prio_pkg::GROUP3_ADDR |=>
      watchdog_level_o == $past(wdata_i[7:6]) &&
      brownout_level_o == $past(wdata_i[15:14]) &&
      nvm_controller_level_o == $past(wdata_i[23:22]) &&
      wakeup_timer_level_o == $past(wdata_i[31:30]))
    else $error("word three write not stored in its lanes");

  chk_word6_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == irq_prio_pkg::GROUP6_ADDR |=>
      {pin_event3_level_o, pin_event2_level_o, pin_event1_level_o, pin_event0_level_o} ==
      {$past(wdata_i[31:30]), $past(wdata_i[23:22]), $past(wdata_i[15:14]),
       $past(wdata_i[7:6])})
    else $error("word six write not stored in its lanes");

  chk_word7_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == irq_prio_pkg::GROUP7_ADDR |=>
      {pin_event7_level_o, pin_event6_level_o, pin_event5_level_o, pin_event4_level_o} ==
      {$past(wdata_i[31:30]), $past(wdata_i[23:22]), $past(wdata_i[15:14]),
       $past(wdata_i[7:6])})
    else $error("word seven write not stored in its lanes");

  chk_lane_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rdata_o & irq_prio_pkg::LANE_ZERO_MASK) == 32'h0000_0000)
    else $error("low lane bits read back nonzero");

  chk_read_lanes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == irq_prio_pkg::GROUP2_ADDR |=>
      rdata_o == {comparator_level_o, 6'h00, multirate_timer_level_o, 6'h00,
                  state_timer_level_o, 6'h00, two_wire_level_o, 6'h00})
    else $error("word two readback does not match its levels");

  chk_reserved_lanes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == irq_prio_pkg::GROUP1_ADDR |=> rdata_o[31:16] == 16'h0000)
    else $error("reserved lanes of word one read nonzero");

  chk_reset_levels: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> state.levels == '0 && !irq_req_valid_o && rdata_o == 32'h0000_0000)
    else $error("levels not zero after reset");

  // gated on the sampled reset: the release edge still loads reset values
  chk_arb_valid: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i |=> irq_req_valid_o == (|$past(cand)))
    else $error("request valid does not follow enabled pending sources");

  chk_arb_member: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_req_valid_o |-> cand_q[irq_req_num_o])
    else $error("presented source was not a candidate");

  chk_arb_best: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_req_valid_o && !$past(wr_i) |->
      !better_seen && irq_req_level_o == state.levels[irq_req_num_o])
    else $error("presented source is not the most urgent");

endmodule : irq_priority_register_bank

//--- bench/irq_core_model.sv
// core-side model: takes the prioritised request presented by the bank
// assumes the core samples the request every cycle, with no handshake back
`timescale 1ns/100ps

module irq_core_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire logic [4:0] req_num_i,
  input wire logic [1:0] req_level_i,
  output logic take_o,
  output logic [4:0] take_num_o,
  output logic [1:0] take_level_o
);
  // the bank gives no ready, so the core sees each pick in its cycle
  int taken = 0;
  assign take_o = req_valid_i;
  assign take_num_o = req_num_i;
  assign take_level_o = req_level_i;
  always @(posedge sys_clk_i) begin
    if (rst_n_i && req_valid_i === 1'b1) begin
      taken <= taken + 1;
    end
  end
endmodule : irq_core_model

//--- bench/irq_priority_register_bank_tb_top.sv
// self-checking bench for the interrupt priority register bank
// assumes the package constants and the one-cycle read latency of the port
`timescale 1ns/100ps

module irq_priority_register_bank_tb_top;
  logic sys_clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, ac = 0, rd_seen = 0, ac_seen = 0;
  logic [31:0] addr_i = 0, wdata_i = 0, rdata_o, pend = 0, en = 0;
  logic v_o, tk;
  logic [4:0] n_o, tn;
  logic [1:0] l_o, tl;
  logic [1:0] lvl [32];
  logic [1:0] exp_lvl [32];
  logic [31:0] rq[$];
  logic [7:0] aq[$];
  int num_errors = 0, n_tests = 0;
  localparam logic [31:0] ADDRS [9] = '{irq_prio_pkg::GROUP0_ADDR, irq_prio_pkg::GROUP1_ADDR,
    irq_prio_pkg::GROUP2_ADDR, irq_prio_pkg::GROUP3_ADDR, irq_prio_pkg::GROUP6_ADDR,
    irq_prio_pkg::GROUP7_ADDR, 32'hE000_E410, 32'hE000_E414, 32'h0000_0404};

  always #5 sys_clk_i = ~sys_clk_i;

  irq_priority_register_bank dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_pending_i(pend),
    .irq_enable_i(en), .irq_req_valid_o(v_o), .irq_req_num_o(n_o), .irq_req_level_o(l_o),
    .serial_port0_level_o(lvl[0]), .serial_port1_level_o(lvl[1]),
    .async_port0_level_o(lvl[3]), .async_port1_level_o(lvl[4]),
    .async_port2_level_o(lvl[5]), .two_wire_level_o(lvl[8]), .state_timer_level_o(lvl[9]),
    .multirate_timer_level_o(lvl[10]), .comparator_level_o(lvl[11]),
    .watchdog_level_o(lvl[12]), .brownout_level_o(lvl[13]),
    .nvm_controller_level_o(lvl[14]), .wakeup_timer_level_o(lvl[15]),
    .pin_event0_level_o(lvl[24]), .pin_event1_level_o(lvl[25]),
    .pin_event2_level_o(lvl[26]), .pin_event3_level_o(lvl[27]),
    .pin_event4_level_o(lvl[28]), .pin_event5_level_o(lvl[29]),
    .pin_event6_level_o(lvl[30]), .pin_event7_level_o(lvl[31]));

  irq_core_model core_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(v_o),
    .req_num_i(n_o), .req_level_i(l_o), .take_o(tk), .take_num_o(tn), .take_level_o(tl));

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic give_verdict();
    // results still owed at the end count as mismatches
    if (rq.size() != 0 || aq.size() != 0) num_errors++;
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------
  function automatic int word_of(input logic [31:0] a);
    for (int i = 0; i < 6; i++) begin
      if (a == ADDRS[i]) begin
        return a[4:2];
      end
    end
    return -1;
  endfunction : word_of

  function automatic logic [31:0] exp_word(input logic [31:0] a);
    logic [31:0] r;
    int w;
    r = 32'h0;
    w = word_of(a);
    if (w >= 0) begin
      for (int k = 0; k < 4; k++) begin
        r[8*k+6 +: 2] = exp_lvl[4*w+k];
      end
    end
    return r;
  endfunction : exp_word

  // strict compare keeps the lower number on a tie
  function automatic logic [7:0] pick(input logic [31:0] c);
    logic [7:0] r;
    r = {1'b0, 5'h0, 2'h3};
    for (int i = 0; i < 32; i++) begin
      if (c[i] && (!r[7] || exp_lvl[i] < r[1:0])) begin
        r = {1'b1, i[4:0], exp_lvl[i]};
      end
    end
    return r;
  endfunction : pick

  // ---------------------------------------------------------------
  // drivers: one edge each, every signal assigned once per edge
  // ---------------------------------------------------------------
  task automatic cyc(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    int g;
    @(posedge sys_clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    ac <= 1'b0;
    g = word_of(a);
    if (w && g >= 0) begin
      for (int k = 0; k < 4; k++) begin
        if (irq_prio_pkg::IMPL_MASK[4*g+k]) exp_lvl[4*g+k] = d[8*k+6 +: 2];
      end
    end
    if (r) rq.push_back(exp_word(a));
  endtask : cyc

  task automatic arb(input logic [31:0] p, input logic [31:0] e);
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    pend <= p;
    en <= e;
    ac <= 1'b1;
    aq.push_back(pick(p & e & irq_prio_pkg::IMPL_MASK));
  endtask : arb

  task automatic read_all();
    foreach (ADDRS[i]) cyc(1'b0, 1'b1, ADDRS[i], 32'h0);
  endtask : read_all

  task automatic chk_lvls();
    #2;
    for (int i = 0; i < 32; i++) begin
      if (irq_prio_pkg::IMPL_MASK[i]) check({30'h0, lvl[i]}, {30'h0, exp_lvl[i]});
    end
  endtask : chk_lvls

  // ---------------------------------------------------------------
  // monitor: results taken off the queues as they appear
  // ---------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    rd_seen <= rd_i;
    ac_seen <= ac;
  end

  always @(negedge sys_clk_i) begin
    if (rd_seen) begin
      if (rq.size() == 0) check(32'h1, 32'h0);
      else check(rdata_o, rq.pop_front());
    end else if (rst_n_i) begin
      // read data stand for one cycle only, zero otherwise
      check(rdata_o, 32'h0000_0000);
    end
    if (ac_seen) begin
      if (aq.size() == 0) check(32'h1, 32'h0);
      else check({24'h0, tk, tn, tl}, {24'h0, aq.pop_front()});
    end
  end

  initial begin
    #300us;
    num_errors++;
    give_verdict();
  end

  initial begin
    logic [31:0] a;
    foreach (exp_lvl[i]) exp_lvl[i] = 2'h0;
    void'($urandom(32'h2d85));
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    read_all();
    chk_lvls();
    foreach (ADDRS[i]) begin
      cyc(1'b1, 1'b0, ADDRS[i], 32'hFFFF_FFFF);
      cyc(1'b0, 1'b1, ADDRS[i], 32'h0);
    end
    chk_lvls();
    for (int i = 0; i < 120; i++) begin
      a = ADDRS[$urandom % 9];
      cyc(1'b1, 1'b0, a, $urandom);
      cyc(1'b0, 1'b1, a, 32'h0);
    end
    chk_lvls();
    // sparse vectors make ties, reserved-only and empty picks common
    for (int i = 0; i < 400; i++) begin
      if (i % 8 == 0) cyc(1'b1, 1'b0, ADDRS[$urandom % 6], $urandom);
      arb($urandom & $urandom & $urandom, $urandom | $urandom);
    end
    cyc(1'b0, 1'b0, 32'h0, 32'h0);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    foreach (exp_lvl[i]) exp_lvl[i] = 2'h0;
    read_all();
    chk_lvls();
    cyc(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    give_verdict();
  end
endmodule : irq_priority_register_bank_tb_top
